/* hw/udb_engine.sv */
/*
  Device-side burst engine: command busy handling, burst request, data-in
  strobing, data-out reception, pause, termination by either side and CRC
  check against the host word sampled at acknowledge negation.
  Assumes a host that keeps its own handshake rules; all pins are retimed.
*/
module udb_engine #(
  parameter logic [udb_pkg::WORD_W-1:0] CRC_POLY = 16'h1021,
  parameter logic [udb_pkg::WORD_W-1:0] CRC_SEED = 16'hffff
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [udb_pkg::MODE_W-1:0] udma_mode,
  input wire logic cmd_start,
  input wire logic cmd_dir_in,
  input wire logic [udb_pkg::CNT_W-1:0] cmd_words,
  input wire logic cmd_abort,
  output logic cmd_done,
  output logic ready_o,
  output logic bsy_o,
  output logic drq_o,
  output logic crc_err_o,
  output logic dmarq_o,
  input wire logic dmack_n,
  input wire logic stop_i,
  input wire logic hrdy_hstb_n,
  output logic drdy_dstb_n,
  input wire logic [udb_pkg::WORD_W-1:0] dd_i,
  output logic [udb_pkg::WORD_W-1:0] dd_o,
  output logic dd_oe,
  input wire logic [udb_pkg::WORD_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic [udb_pkg::WORD_W-1:0] rx_data,
  output logic rx_valid,
  input wire logic rx_pause
);
  // Engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_WAIT, ST_REQ, ST_IN_INIT, ST_IN_XFER, ST_IN_FIN,
    ST_OUT_XFER, ST_OUT_PAUSE, ST_TERM_WAIT, ST_END
  } udb_state_t;

  // Synchroniser carrier
  udb_sync_if #(.W(udb_pkg::SYNC_W)) sif ();
  // Retimed pins
  logic s_dmack_n;
  logic s_stop;
  logic s_hpin_n;
  logic [udb_pkg::WORD_W-1:0] s_dd;
  // Decoded pin meanings
  logic s_ack;
  logic s_hrdy;
  logic hs_edge;
  // Control state
  udb_state_t st_reg;
  logic dir_in_reg;
  logic [udb_pkg::CNT_W-1:0] words_reg;
  logic [udb_pkg::TMR_W-1:0] cnt_reg;
  logic dat_ok_reg;
  logic first_reg;
  logic hs_prev_reg;
  logic [udb_pkg::WORD_W-1:0] crc_reg;
  logic [udb_pkg::TMR_W-1:0] gap_c;
  logic [udb_pkg::TMR_W-1:0] rp_c;
  // Data-in strobe and load decisions, data-out take decision
  logic stb_fire;
  logic load_go;
  logic rx_take;
  // Output registers
  logic ready_reg;
  logic bsy_reg;
  logic drq_reg;
  logic crc_err_reg;
  logic dmarq_reg;
  logic dstb_reg;
  logic [udb_pkg::WORD_W-1:0] dd_reg;
  logic dd_oe_reg;
  logic rx_valid_reg;
  logic [udb_pkg::WORD_W-1:0] rx_data_reg;
  logic done_reg;

  // Pins pass two flip-flops before use
  assign sif.raw = {dmack_n, stop_i, hrdy_hstb_n, dd_i};
  udb_sync #(.RST_VAL({3'b101, 16'h0000})) u_sync (
    .mclk(mclk),
    .rst(rst),
    .sif(sif)
  );
  assign {s_dmack_n, s_stop, s_hpin_n, s_dd} = sif.sync;

  // Pin meanings; the shared host pin is ready in data-in, strobe in data-out
  assign s_ack = ~s_dmack_n;
  assign s_hrdy = ~s_hpin_n;
  assign hs_edge = (s_hpin_n != hs_prev_reg);
  assign gap_c = udb_pkg::gap_cyc(udma_mode);
  assign rp_c = udb_pkg::rp_cyc(udma_mode);

  // Strobe a loaded word once spacing is met and the host is ready
  assign stb_fire = (st_reg == ST_IN_XFER) && !s_stop && (cnt_reg == '0) && dat_ok_reg &&
                    s_hrdy;
  // Fetch the next word after each strobe, while words remain
  assign load_go = (st_reg == ST_IN_XFER || st_reg == ST_IN_INIT) && !s_stop && !dat_ok_reg &&
                   tx_valid && (words_reg != '0);
  assign tx_ready = load_go;
  // Accept host words only while request is high and stop is low
  assign rx_take = !dir_in_reg && (st_reg == ST_OUT_XFER || st_reg == ST_OUT_PAUSE) &&
                   hs_edge && dmarq_reg && !s_stop;

  // Strobe edge history
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hs_prev_reg <= 1'b1;
    end else begin
      hs_prev_reg <= s_hpin_n;
    end
  end

  // Burst and command sequencing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_reg <= ST_IDLE;
      dir_in_reg <= 1'b0;
      words_reg <= '0;
      cnt_reg <= '0;
      first_reg <= 1'b0;
      dmarq_reg <= 1'b0;
      dstb_reg <= udb_pkg::STB_RST;
      dd_oe_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (cmd_abort) begin
        // Abort ends the command and drops the burst lines
        st_reg <= ST_IDLE;
        dmarq_reg <= 1'b0;
        dstb_reg <= udb_pkg::STB_RST;
        dd_oe_reg <= 1'b0;
      end else begin
        if (stb_fire || rx_take) begin
          words_reg <= words_reg - 16'h0001;
        end
        case (st_reg)
          ST_IDLE: begin
            // New command with a nonzero length
            if (cmd_start && cmd_words != '0) begin
              dir_in_reg <= cmd_dir_in;
              words_reg <= cmd_words;
              st_reg <= ST_WAIT;
            end
          end
          ST_WAIT: begin
            // Request a burst once the user side can move data; a word still held
            // from a cut burst counts as ready data
            if (dir_in_reg ? (tx_valid || dat_ok_reg) : !rx_pause) begin
              dmarq_reg <= 1'b1;
              first_reg <= 1'b0;
              st_reg <= ST_REQ;
            end
          end
          ST_REQ: begin
            // Request held until the host acknowledges
            if (s_ack) begin
              if (dir_in_reg) begin
                st_reg <= ST_IN_INIT;
              end else begin
                dstb_reg <= 1'b0;
                st_reg <= ST_OUT_XFER;
              end
            end
          end
          ST_IN_INIT: begin
            // Take the bus only with ack, stop low and host ready
            if (s_ack && !s_stop && s_hrdy) begin
              dd_oe_reg <= 1'b1;
              cnt_reg <= gap_c - 4'h1;
              st_reg <= ST_IN_XFER;
            end
          end
          ST_IN_XFER: begin
            if (s_stop) begin
              // Host terminates: answer by dropping the request
              dmarq_reg <= 1'b0;
              st_reg <= ST_IN_FIN;
            end else if (stb_fire) begin
              dstb_reg <= ~dstb_reg;
              first_reg <= 1'b1;
              cnt_reg <= gap_c - 4'h1;
            end else if (cnt_reg != '0) begin
              cnt_reg <= cnt_reg - 4'h1;
            end else if (words_reg == '0 && !dat_ok_reg && first_reg) begin
              // All words sent and last strobe old enough: request end
              dmarq_reg <= 1'b0;
              st_reg <= ST_TERM_WAIT;
            end
          end
          ST_IN_FIN: begin
            // Strobe back to asserted level with no data and release bus in the same cycle
            dstb_reg <= 1'b1;
            dd_oe_reg <= 1'b0;
            st_reg <= ST_END;
          end
          ST_OUT_XFER: begin
            if (rx_take) begin
              first_reg <= 1'b1;
            end
            if (s_stop) begin
              // Host sender terminates
              dmarq_reg <= 1'b0;
              st_reg <= ST_END;
            end else if (words_reg == '0 || (rx_take && words_reg == 16'h0001)) begin
              // Pause first, then wait before terminating
              dstb_reg <= 1'b1;
              cnt_reg <= rp_c - 4'h1;
              st_reg <= ST_OUT_PAUSE;
            end else if (first_reg || rx_take) begin
              dstb_reg <= rx_pause;
            end
          end
          ST_OUT_PAUSE: begin
            // Words may still arrive while paused
            if (s_stop) begin
              dmarq_reg <= 1'b0;
              st_reg <= ST_END;
            end else if (cnt_reg != '0) begin
              cnt_reg <= cnt_reg - 4'h1;
            end else begin
              dmarq_reg <= 1'b0;
              st_reg <= ST_TERM_WAIT;
            end
          end
          ST_TERM_WAIT: begin
            // Strobe frozen and ready negated until host answers with stop
            if (s_stop) begin
              st_reg <= dir_in_reg ? ST_IN_FIN : ST_END;
            end
          end
          ST_END: begin
            // Acknowledge negation ends the burst, lines revert
            dd_oe_reg <= 1'b0;
            dstb_reg <= 1'b1;
            if (!s_ack) begin
              if (words_reg == '0) begin
                done_reg <= 1'b1;
                st_reg <= ST_IDLE;
              end else begin
                st_reg <= ST_WAIT;
              end
            end
          end
          default: begin
            st_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // Outgoing word register for data-in bursts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dd_reg <= '0;
      dat_ok_reg <= 1'b0;
    end else if (st_reg == ST_IDLE) begin
      // A word loaded before a host stop is kept and sent first next burst
      dat_ok_reg <= 1'b0;
    end else if (stb_fire) begin
      dat_ok_reg <= 1'b0;
    end else if (load_go) begin
      dd_reg <= tx_data;
      dat_ok_reg <= 1'b1;
    end
  end

  // Received word register for data-out bursts
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_data_reg <= '0;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rx_take;
      if (rx_take) begin
        rx_data_reg <= s_dd;
      end
    end
  end

  // CRC over words moved, checked against the host word at burst end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_reg <= CRC_SEED;
      crc_err_reg <= 1'b0;
    end else begin
      if (st_reg == ST_REQ) begin
        crc_reg <= CRC_SEED;
      end else if (stb_fire) begin
        crc_reg <= udb_pkg::crc_step(crc_reg, dd_reg, CRC_POLY);
      end else if (rx_take) begin
        crc_reg <= udb_pkg::crc_step(crc_reg, s_dd, CRC_POLY);
      end
      if (st_reg == ST_END && !s_ack && s_dd != crc_reg) begin
        crc_err_reg <= 1'b1;
      end else if (cmd_start && st_reg == ST_IDLE) begin
        crc_err_reg <= 1'b0;
      end
    end
  end

  // Ready line and busy / data-request status
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ready_reg <= 1'b1;
      bsy_reg <= 1'b0;
      drq_reg <= 1'b0;
    end else if (cmd_abort || done_reg) begin
      ready_reg <= 1'b1;
      bsy_reg <= 1'b0;
      drq_reg <= 1'b0;
    end else if (st_reg == ST_IDLE && cmd_start && cmd_words != '0) begin
      ready_reg <= 1'b0;
      bsy_reg <= 1'b1;
    end else if (st_reg == ST_REQ) begin
      drq_reg <= 1'b1;
      bsy_reg <= 1'b0;
    end
  end

  assign ready_o = ready_reg;
  assign bsy_o = bsy_reg;
  assign drq_o = drq_reg;
  assign crc_err_o = crc_err_reg;
  assign dmarq_o = dmarq_reg;
  assign drdy_dstb_n = dstb_reg;
  assign dd_o = dd_reg;
  assign dd_oe = dd_oe_reg;
  assign rx_data = rx_data_reg;
  assign rx_valid = rx_valid_reg;
  assign cmd_done = done_reg;

  // Cycles the data-out ready has been negated, for the pause check
  logic [udb_pkg::TMR_W-1:0] pause_age_reg;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pause_age_reg <= '0;
    end else if (!dstb_reg || dir_in_reg) begin
      pause_age_reg <= '0;
    end else if (pause_age_reg != 4'hf) begin
      pause_age_reg <= pause_age_reg + 4'h1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  AST_READY_BUSY: assert property (st_reg != ST_IDLE |-> !ready_o)
    else $error("ready line not busy during command");
  AST_BSY_OR_DRQ: assert property (st_reg != ST_IDLE && !cmd_abort |-> bsy_o || drq_o)
    else $error("busy and data request both clear");
  AST_DRIVE_COND: assert property ($rose(dd_oe) |-> $past(s_ack && !s_stop && s_hrdy))
    else $error("bus driven before ack, stop and ready");
  AST_REQ_HOLD: assert property (st_reg == ST_REQ && !cmd_abort |=> dmarq_o)
    else $error("request dropped before first strobe");
  AST_NO_STB_UNRDY: assert property (st_reg == ST_IN_XFER && !s_hrdy |=> $stable(dstb_reg))
    else $error("strobe moved while host not ready");
  AST_STB_GAP: assert property (stb_fire |=> !stb_fire)
    else $error("strobe edges too close");
  AST_PAUSE_FIRST: assert property ($fell(dmarq_o) && !dir_in_reg && !$past(s_stop) &&
                                    !$past(cmd_abort) |-> pause_age_reg >= rp_c)
    else $error("terminated without full pause");
  AST_HOST_STOP: assert property ((st_reg == ST_IN_XFER || st_reg == ST_OUT_XFER) && s_stop &&
                                  !cmd_abort |=> !dmarq_o)
    else $error("host stop not answered");
  AST_RDY_NEG: assert property (st_reg == ST_TERM_WAIT && !dir_in_reg |-> drdy_dstb_n)
    else $error("ready reasserted after termination request");
  AST_IGNORE_STB: assert property (rx_valid |-> $past(dmarq_o && !s_stop))
    else $error("word taken while request low or stop high");
  AST_REVERT: assert property (st_reg == ST_END && !s_ack && !cmd_abort |=>
                               !dd_oe && drdy_dstb_n && !dmarq_o)
    else $error("lines not reverted at burst end");
  AST_CRC_KEEP: assert property (crc_err_o && !cmd_start |=> crc_err_o)
    else $error("crc error lost within command");

  COV_IN_DONE: cover property (done_reg && dir_in_reg);
  COV_OUT_DONE: cover property (done_reg && !dir_in_reg);
  COV_HOST_TERM: cover property (st_reg == ST_IN_XFER && s_stop);
  COV_CRC_ERR: cover property ($rose(crc_err_o));
endmodule : udb_engine

/* inc/udb_pkg.sv */
/*
  Shared constants and helpers for the burst engine: clock rate, per-mode
  protocol intervals, derived cycle counts, word width and CRC step.
  Assumes a single core clock whose period is CLK_NS.
*/
package udb_pkg;
  // Core clock period
  localparam int CLK_NS = 100;
  // Data word width in a burst
  localparam int WORD_W = 16;
  // Highest supported transfer mode
  localparam int MODE_MAX = 4;
  // Width of the mode select
  localparam int MODE_W = 3;
  // Width of the word counter
  localparam int CNT_W = 16;
  // Width of the interval timer
  localparam int TMR_W = 4;
  // Least strobe edge spacing per mode
  localparam int T_CYC_NS [5] = '{112, 73, 54, 39, 25};
  // Least ready-to-pause wait per mode
  localparam int T_RP_NS [5] = '{160, 125, 100, 100, 100};
  // Least time from last strobe to a sender termination
  localparam int T_SS_NS = 50;
  // Strobe spacing never below two cycles: one to set data, one to strobe
  localparam int GAP_FLOOR = 2;
  // Number of pin inputs that pass the synchroniser
  localparam int SYNC_W = WORD_W + 3;
  // Reset level of the strobe / ready output pin
  localparam logic STB_RST = 1'b1;

  // Least time in whole cycles, rounded up, never below one
  function automatic int min_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : min_cyc

  // Strobe gap in cycles for a mode
  function automatic logic [TMR_W-1:0] gap_cyc(input logic [MODE_W-1:0] m);
    int c;
    int i;
    i = (int'(m) > MODE_MAX) ? MODE_MAX : int'(m);
    c = min_cyc(T_CYC_NS[i]);
    c = (c < GAP_FLOOR) ? GAP_FLOOR : c;
    return TMR_W'(c);
  endfunction : gap_cyc

  // Ready-to-pause wait in cycles for a mode
  function automatic logic [TMR_W-1:0] rp_cyc(input logic [MODE_W-1:0] m);
    int i;
    i = (int'(m) > MODE_MAX) ? MODE_MAX : int'(m);
    return TMR_W'(min_cyc(T_RP_NS[i]));
  endfunction : rp_cyc

  // Last-strobe to termination wait in cycles
  localparam logic [TMR_W-1:0] SS_CYC = TMR_W'(min_cyc(T_SS_NS));

  // One CRC step over a whole word, MSB first
  function automatic logic [WORD_W-1:0] crc_step(input logic [WORD_W-1:0] crc,
                                                 input logic [WORD_W-1:0] d,
                                                 input logic [WORD_W-1:0] poly);
    logic [WORD_W-1:0] c;
    c = crc;
    for (int k = WORD_W - 1; k >= 0; k--) begin
      c = (c[WORD_W-1] ^ d[k]) ? ((c << 1) ^ poly) : (c << 1);
    end
    return c;
  endfunction : crc_step
endpackage : udb_pkg

/* inc/udb_sync_if.sv */
/*
  Carrier between the engine and its pin synchroniser: raw pin levels in,
  retimed levels out.
  Assumes both ends run on the core clock.
*/
interface udb_sync_if #(
  parameter int W = udb_pkg::SYNC_W
);
  // Pin levels straight from outside
  logic [W-1:0] raw;
  // Levels after two flip-flops
  logic [W-1:0] sync;
  // Engine side
  modport engine (output raw, input sync);
  // Synchroniser side
  modport syncer (input raw, output sync);
endinterface : udb_sync_if

/* hw/udb_sync.sv */
/*
  Two flip-flop synchroniser for the pin inputs.
  Assumes raw levels are asynchronous to mclk; only the second stage is read.
*/
module udb_sync #(
  parameter logic [udb_pkg::SYNC_W-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst,
  udb_sync_if.syncer sif
);
  // First stage, read by the second stage only
  logic [udb_pkg::SYNC_W-1:0] meta_reg;
  // Second stage, the retimed output
  logic [udb_pkg::SYNC_W-1:0] sync_reg;

  // Two stages of retiming
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= sif.raw;
      sync_reg <= meta_reg;
    end
  end

  assign sif.sync = sync_reg;
endmodule : udb_sync

/* sim/udb_host_model.sv */
/*
  Behavioural host at the far end of the burst port: acknowledges requests,
  takes or sends words, ends bursts and returns its CRC word.
  Assumes the engine retimes these pins on its own core clock.
*/
module udb_host_model (
  input wire logic dmarq,
  input wire logic dstb,
  input wire logic dd_oe,
  input wire logic [15:0] dd,
  input wire logic dir_in,
  input wire logic bad_crc,
  input wire logic [15:0] out_base,
  output logic dmack_n,
  output logic stop,
  output logic hs,
  output logic [15:0] h_dd
);
  timeunit 1ns;
  timeprecision 1ps;
  int stop_after = 0; // Words before the host pauses and ends, 0 never
  int n_got = 0; // Words taken in data-in
  int sent = 0; // Words sent in data-out
  int bursts = 0; // Bursts acknowledged
  int k; // Words in this burst
  logic [15:0] got [64]; // Words taken in data-in
  logic [15:0] crc; // Running CRC of this burst
  logic last; // Last strobe level seen
  realtime t0; // Moment the host paused

  // Own CRC step, MSB first
  function automatic logic [15:0] crc_f(input logic [15:0] c, input logic [15:0] d);
    for (int b = 15; b >= 0; b--) c = (c[15] ^ d[b]) ? ((c << 1) ^ 16'h1021) : (c << 1);
    return c;
  endfunction : crc_f

  // One burst per request: acknowledge, move words, close with CRC
  initial begin
    dmack_n = 1'b1;
    stop = 1'b0;
    hs = 1'b1;
    h_dd = 16'h0000;
    forever begin
      wait (dmarq === 1'b1);
      #150 dmack_n = 1'b0;
      #40 hs = ~dir_in;
      crc = 16'hffff;
      last = dstb;
      k = 0;
      bursts++;
      if (dir_in) begin
        // Poll the strobe; both edges carry a word
        while (dmarq === 1'b1) begin
          #10;
          if (dstb !== last) begin
            last = dstb;
            if (!stop) begin
              got[n_got] = dd;
              crc = crc_f(crc, dd);
              n_got++;
              k++;
              if (k == stop_after) begin
                hs = 1'b1;
                t0 = $realtime;
              end
            end
          end
          if (hs && !stop && $realtime - t0 >= 400) stop = 1'b1;
        end
      end else begin
        wait (dstb === 1'b0);
        // Step off the core clock edge so pins never move as they are sampled
        #20;
        // Strobe a word only while the engine is ready; data held on both sides
        while (dmarq === 1'b1) begin
          h_dd = out_base + 16'(sent);
          #200;
          if (dmarq !== 1'b1) break;
          if (dstb === 1'b0) begin
            hs = ~hs;
            crc = crc_f(crc, h_dd);
            sent++;
          end
          #200;
        end
      end
      stop = 1'b1;
      #200;
      if (!hs) hs = 1'b1;
      wait (dstb === 1'b1 && dd_oe === 1'b0);
      h_dd = crc ^ {16{bad_crc}};
      #400 dmack_n = 1'b1;
      #600 h_dd = ~h_dd;
      stop = 1'b0;
    end
  end
endmodule : udb_host_model

/* sim/tb.sv */
/*
  Self-checking bench for the burst engine with a behavioural host.
  Assumes the engine's default CRC parameters and a 10 MHz core clock.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] udma_mode = 3'h0;
  logic cmd_start = 1'b0;
  logic cmd_dir_in = 1'b0;
  logic [15:0] cmd_words = 16'h0000;
  logic cmd_abort = 1'b0;
  logic cmd_done, ready_o, bsy_o, drq_o, crc_err_o, dmarq_o, drdy_dstb_n, dd_oe;
  logic dmack_n, h_stop, h_hs, tx_ready, rx_valid;
  logic [15:0] dd_o, h_dd, rx_data;
  logic [15:0] tx_data = 16'h0000;
  logic tx_valid = 1'b0;
  logic rx_pause = 1'b0;
  logic h_dir = 1'b0;
  logic h_bad = 1'b0;
  logic [15:0] dd_bus; // Shared data wire
  int tx_left = 0; // Data-in words still to hand over
  int errors = 0;
  int check_count = 0;
  int paused_n = 0; // Words delivered while paused
  int tcyc [5] = '{112, 73, 54, 39, 25}; // Least strobe spacing per mode
  realtime t_edge = 0;
  logic [15:0] rxq [$]; // Words delivered to the user

  assign dd_bus = dd_oe ? dd_o : h_dd;
  always #50 mclk = ~mclk;

  udb_engine uut (.mclk(mclk), .rst(rst), .udma_mode(udma_mode), .cmd_start(cmd_start),
    .cmd_dir_in(cmd_dir_in), .cmd_words(cmd_words), .cmd_abort(cmd_abort),
    .cmd_done(cmd_done), .ready_o(ready_o), .bsy_o(bsy_o), .drq_o(drq_o),
    .crc_err_o(crc_err_o), .dmarq_o(dmarq_o), .dmack_n(dmack_n), .stop_i(h_stop),
    .hrdy_hstb_n(h_hs), .drdy_dstb_n(drdy_dstb_n), .dd_i(dd_bus), .dd_o(dd_o),
    .dd_oe(dd_oe), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_pause(rx_pause));
  udb_host_model host (.dmarq(dmarq_o), .dstb(drdy_dstb_n), .dd_oe(dd_oe), .dd(dd_bus),
    .dir_in(h_dir), .bad_crc(h_bad), .out_base(16'hb700), .dmack_n(dmack_n),
    .stop(h_stop), .hs(h_hs), .h_dd(h_dd));

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Verdict and end of run
  task automatic wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // User side of data-in: next word after each take
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      tx_data <= tx_data + 16'h0001;
      tx_left <= tx_left - 1;
      if (tx_left == 1) tx_valid <= 1'b0;
    end
  end

  // Collect delivered words
  always @(posedge mclk) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_data);
      if (rx_pause) paused_n++;
    end
  end

  // Bus driven only inside an acknowledged, unstopped burst
  always @(posedge dd_oe) begin
    check(dmack_n, 1'b0);
    check(h_stop, 1'b0);
  end

  // Device strobe spacing
  always @(drdy_dstb_n) begin
    if (dd_oe === 1'b1) check($realtime - t_edge >= tcyc[udma_mode], 1'b1);
    t_edge = $realtime;
  end

  // One command, start to completion
  task automatic run_cmd(input logic din, input logic [2:0] mode, input logic [15:0] n);
    int i;
    @(posedge mclk);
    udma_mode <= mode;
    cmd_dir_in <= din;
    cmd_words <= n;
    cmd_start <= 1'b1;
    h_dir <= din;
    tx_valid <= din;
    tx_left <= n;
    tx_data <= 16'ha500;
    @(posedge mclk);
    cmd_start <= 1'b0;
    @(posedge mclk);
    @(negedge mclk);
    check(ready_o, 1'b0);
    check(bsy_o | drq_o, 1'b1);
    for (i = 0; i < 30000 && cmd_done !== 1'b1; i++) begin
      @(negedge mclk);
      if (cmd_done !== 1'b1) check(ready_o, 1'b0);
    end
    check(cmd_done, 1'b1);
    @(negedge mclk);
    check(ready_o, 1'b1);
    check(dmarq_o, 1'b0);
    check(dd_oe, 1'b0);
  endtask : run_cmd

  // Data-in command, optionally ended early by the host each burst
  task automatic s_din(input logic [2:0] mode, input int n, input int stop_after);
    int b;
    host.n_got = 0;
    host.stop_after = stop_after;
    b = host.bursts;
    run_cmd(1'b1, mode, 16'(n));
    check(host.n_got, n);
    for (int i = 0; i < n; i++) check(host.got[i], 16'ha500 + 16'(i));
    check(crc_err_o, 1'b0);
    if (stop_after != 0) check(host.bursts - b >= 2, 1'b1);
  endtask : s_din

  // Data-out command with good or corrupt host CRC
  task automatic s_dout(input logic [2:0] mode, input int n, input logic bad);
    host.sent = 0;
    h_bad <= bad;
    rxq.delete();
    run_cmd(1'b0, mode, 16'(n));
    check(rxq.size(), n);
    for (int i = 0; i < n; i++) check(rxq[i], 16'hb700 + 16'(i));
    check(crc_err_o, bad);
    h_bad <= 1'b0;
  endtask : s_dout

  // User pause in mid data-out, then resume
  task automatic s_pause;
    host.sent = 0;
    rxq.delete();
    fork
      run_cmd(1'b0, 3'h1, 16'h0008);
      begin
        wait (rxq.size() == 1);
        @(posedge mclk);
        rx_pause <= 1'b1;
        paused_n = 0;
        repeat (60) @(posedge mclk);
        check(paused_n <= 3, 1'b1);
        check(drdy_dstb_n, 1'b1);
        rx_pause <= 1'b0;
      end
    join
    check(rxq.size(), 8);
  endtask : s_pause

  // Abort in mid data-out burst drops the request and returns ready at once
  task automatic s_abort;
    rxq.delete();
    @(posedge mclk);
    cmd_dir_in <= 1'b0;
    cmd_words <= 16'h0008;
    cmd_start <= 1'b1;
    h_dir <= 1'b0;
    @(posedge mclk);
    cmd_start <= 1'b0;
    wait (rxq.size() == 1);
    @(posedge mclk);
    cmd_abort <= 1'b1;
    @(posedge mclk);
    cmd_abort <= 1'b0;
    @(negedge mclk);
    check(dmarq_o, 1'b0);
    check(ready_o, 1'b1);
    check(bsy_o | drq_o | cmd_done, 1'b0);
    repeat (20) @(posedge mclk);
    check(dmack_n, 1'b1);
  endtask : s_abort

  // Main sequence
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check(ready_o, 1'b1);
    check(drdy_dstb_n, 1'b1);
    check(dd_oe, 1'b0);
    s_din(3'h0, 4, 0);
    s_din(3'h3, 6, 2);
    s_dout(3'h4, 5, 1'b0);
    s_dout(3'h2, 3, 1'b1);
    s_dout(3'h0, 2, 1'b0);
    s_pause;
    s_abort;
    wrap_up;
  end

  // Watchdog
  initial begin
    #2000000;
    errors++;
    wrap_up;
  end
endmodule : tb
